// File: verilog/dtc_pkg.sv
// dtc_pkg: constants and carrier types for the dual timer/counter block
// assumes an 8-bit special-register port from the core; offsets are byte addresses

package dtc_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL_FLAGS = 8'h88;  // timer_control_flags
  localparam logic [7:0] OFS_MODE_CONFIG   = 8'h89;  // timer_mode_config
  localparam logic [7:0] OFS_LOW_FIRST     = 8'h8A;  // count_low_first
  localparam logic [7:0] OFS_LOW_SECOND    = 8'h8B;  // count_low_second
  localparam logic [7:0] OFS_HIGH_FIRST    = 8'h8C;  // count_high_first
  localparam logic [7:0] OFS_HIGH_SECOND   = 8'h8D;  // count_high_second

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] RST_CONTROL_FLAGS = 8'h00;
  localparam logic [7:0] RST_MODE_CONFIG   = 8'h00;
  localparam logic [7:0] RST_COUNT         = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int POS_OVF_SECOND  = 7;  // overflow_flag_second
  localparam int POS_RUN_SECOND  = 6;  // run_bit_second
  localparam int POS_OVF_FIRST   = 5;  // overflow_flag_first
  localparam int POS_RUN_FIRST   = 4;  // run_bit_first
  localparam int POS_GATE        = 3;  // gating bit within a mode nibble
  localparam int POS_SELECT      = 2;  // counter/timer select within a nibble
  localparam int POS_MODE_HIGH   = 1;  // mode_field_high within a nibble
  localparam int POS_MODE_LOW    = 0;  // mode_field_low within a nibble
  localparam int PRESCALE_BITS   = 5;  // prescaler width in mode 00

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_HZ        = 20000000;
  localparam int MACHINE_CYCLES  = 1;  // core clocks per machine cycle
  localparam int EDGE_DETECT_MC  = 2;  // machine cycles to see a falling edge

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    DTC_MODE_PRESCALE,
    DTC_MODE_SIXTEEN,
    DTC_MODE_RELOAD,
    DTC_MODE_SPLIT
  } dtc_mode_t;

  // one timer's configuration nibble
  typedef struct packed {
    logic      gate;
    logic      select;
    dtc_mode_t mode;
  } dtc_cfg_t;

  // register port write request
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } dtc_wreq_t;

endpackage

// File: verilog/dtc_edge_sense.sv
// dtc_edge_sense: synchronises a count pin and flags a high-then-low sample pair
// assumes the pin is asynchronous and holds each level a full machine cycle

`timescale 1ns/1ns

module dtc_edge_sense (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // pin and result
  input  wire logic pin,
  output logic      fall
);

  // ************************************************************
  // synchroniser and sample history
  // ************************************************************
  logic sync_a;  // first stage, read only by sync_b
  logic sync_b;  // second stage, first usable sample
  logic prev;    // sample of the previous machine cycle

  // two-stage sync then one sample of history
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev   <= sync_b;
      fall   <= prev & ~sync_b;
    end
  end

  // a fall is one cycle wide and needs a high sample before it
  fall_pulse_a: assert property (@(posedge clock) disable iff (rst)
    fall |=> !fall) else $error("fall pulse longer than one cycle");

endmodule // dtc_edge_sense

// File: verilog/dtc_timer.sv
// dtc_timer: two 16-bit timer/counters with mode and control registers
// assumes the core drives an 8-bit register port on the same clock and
// raises an acknowledge when it vectors to a timer interrupt routine
//
// Functional notes
// - counter mode samples pin each machine cycle
// - falling edge needs two samples, half rate
// - second gate bit adds gate pin qualification
// - first gate bit adds gate pin qualification
// - second select bit picks pin or clock
// - first select bit picks pin or clock
// - second mode 00 prescaled, 11 stops
// - first mode 00 uses five-bit prescaler
// - mode 01 is cascaded 16-bit counter
// - mode 10 reloads low from high
// - first split low byte uses own controls
// - first split high byte uses second run
// - timer mode counts every machine cycle
// - run bits start and stop timers
// - overflow sets flag, vector acknowledge clears

`timescale 1ns/1ns

module dtc_timer (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // register port
  input  wire dtc_pkg::dtc_wreq_t reg_wreq,
  input  wire logic [7:0]        reg_raddr,
  output logic [7:0]             reg_rdata,
  // interrupt vector acknowledges
  input  wire logic              vector_ack_first,
  input  wire logic              vector_ack_second,
  // pins
  input  wire logic              count_pin_first,
  input  wire logic              count_pin_second,
  input  wire logic              gate_pin_first,
  input  wire logic              gate_pin_second,
  // flag outputs
  output logic                   overflow_flag_first,
  output logic                   overflow_flag_second
);

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] timer_mode_config;   // two config nibbles
  logic       run_bit_first;       // software run control
  logic       run_bit_second;      // software run control
  logic [7:0] count_low_first;     // first timer low byte
  logic [7:0] count_high_first;    // first timer high byte
  logic [7:0] count_low_second;    // second timer low byte
  logic [7:0] count_high_second;   // second timer high byte
  logic [1:0] gate_sa;             // gate pins, first stage
  logic [1:0] gate_sb;             // gate pins, usable

  // ************************************************************
  // pin edge detectors
  // ************************************************************
  logic fall_first;   // falling edge on first count pin
  logic fall_second;  // falling edge on second count pin

  dtc_edge_sense u_edge_first (
    .clock (clock),
    .rst   (rst),
    .pin   (count_pin_first),
    .fall  (fall_first)
  );

  dtc_edge_sense u_edge_second (
    .clock (clock),
    .rst   (rst),
    .pin   (count_pin_second),
    .fall  (fall_second)
  );

  // gate pins pass two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_sa <= 2'h0;
      gate_sb <= 2'h0;
    end else begin
      gate_sa <= {gate_pin_second, gate_pin_first};
      gate_sb <= gate_sa;
    end
  end

  // ************************************************************
  // decode
  // ************************************************************
  dtc_pkg::dtc_cfg_t cfg_first;   // low nibble
  dtc_pkg::dtc_cfg_t cfg_second;  // high nibble
  assign cfg_first  = dtc_pkg::dtc_cfg_t'(timer_mode_config[3:0]);
  assign cfg_second = dtc_pkg::dtc_cfg_t'(timer_mode_config[7:4]);

  // enable: run bit, optionally qualified by gate pin
  function automatic logic run_enable(input logic run, input logic gate, input logic pin);
    run_enable = run & (~gate | pin);
  endfunction

  // tick source: pin falling edge or every machine cycle
  function automatic logic tick_src(input logic sel, input logic fall);
    tick_src = sel ? fall : 1'b1;
  endfunction

  wire en_first  = run_enable(run_bit_first, cfg_first.gate, gate_sb[0]);
  wire en_second = run_enable(run_bit_second, cfg_second.gate, gate_sb[1]);
  wire tick_first  = en_first & tick_src(cfg_first.select, fall_first);
  wire tick_second = en_second & tick_src(cfg_second.select, fall_second);
  wire split_mode  = (cfg_first.mode == dtc_pkg::DTC_MODE_SPLIT);
  // in split mode the high byte of the first timer counts machine cycles
  wire tick_split  = run_bit_second;

  wire wr_ctl   = reg_wreq.wr && reg_wreq.addr == dtc_pkg::OFS_CONTROL_FLAGS;
  wire wr_mode  = reg_wreq.wr && reg_wreq.addr == dtc_pkg::OFS_MODE_CONFIG;
  wire wr_lo_f  = reg_wreq.wr && reg_wreq.addr == dtc_pkg::OFS_LOW_FIRST;
  wire wr_hi_f  = reg_wreq.wr && reg_wreq.addr == dtc_pkg::OFS_HIGH_FIRST;
  wire wr_lo_s  = reg_wreq.wr && reg_wreq.addr == dtc_pkg::OFS_LOW_SECOND;
  wire wr_hi_s  = reg_wreq.wr && reg_wreq.addr == dtc_pkg::OFS_HIGH_SECOND;

  // ************************************************************
  // next count for one timer
  // ************************************************************
  // returns {overflow, high, low}; high_tick is used only in split mode
  function automatic logic [16:0] step(input dtc_pkg::dtc_mode_t mode, input logic tick,
                                       input logic high_tick, input logic is_first,
                                       input logic [7:0] lo, input logic [7:0] hi);
    logic [8:0] lo_n;
    logic [8:0] hi_n;
    logic [5:0] pre;
    step = {1'b0, hi, lo};
    lo_n = {1'b0, lo} + 9'h001;
    hi_n = {1'b0, hi} + 9'h001;
    pre  = {1'b0, lo[dtc_pkg::PRESCALE_BITS-1:0]} + 6'h01;
    case (mode)
      dtc_pkg::DTC_MODE_PRESCALE: begin
        if (tick) begin
          step[4:0] = pre[4:0];
          if (pre[5]) begin
            step[15:8] = hi_n[7:0];
            step[16]   = hi_n[8];
          end
        end
      end
      dtc_pkg::DTC_MODE_SIXTEEN: begin
        if (tick) begin
          step[7:0] = lo_n[7:0];
          if (lo_n[8]) begin
            step[15:8] = hi_n[7:0];
            step[16]   = hi_n[8];
          end
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        if (tick) begin
          step[7:0] = lo_n[8] ? hi : lo_n[7:0];
          step[16]  = lo_n[8];
        end
      end
      dtc_pkg::DTC_MODE_SPLIT: begin
        if (is_first) begin
          if (tick) begin
            step[7:0] = lo_n[7:0];
          end
          if (high_tick) begin
            step[15:8] = hi_n[7:0];
          end
        end
      end
      default: begin                     // not reached; second timer mode 11 stop is in the split branch
        step = {1'b0, hi, lo};
      end
    endcase
  endfunction

  wire [16:0] next_first  = step(cfg_first.mode, tick_first, tick_split, 1'b1,
                                 count_low_first, count_high_first);
  wire [16:0] next_second = step(cfg_second.mode, tick_second, 1'b0, 1'b0,
                                 count_low_second, count_high_second);
  // split mode: low byte wraps set the first flag, high byte wraps the second
  wire split_ovf_first  = split_mode & tick_first & (&count_low_first);
  wire split_ovf_second = split_mode & tick_split & (&count_high_first);
  wire set_ovf_first    = next_first[16] | split_ovf_first;
  wire set_ovf_second   = split_mode ? split_ovf_second : next_second[16];

  // ************************************************************
  // counters, write wins over increment
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_low_first   <= dtc_pkg::RST_COUNT;
      count_high_first  <= dtc_pkg::RST_COUNT;
      count_low_second  <= dtc_pkg::RST_COUNT;
      count_high_second <= dtc_pkg::RST_COUNT;
    end else begin
      count_low_first   <= wr_lo_f ? reg_wreq.data : next_first[7:0];
      count_high_first  <= wr_hi_f ? reg_wreq.data : next_first[15:8];
      count_low_second  <= wr_lo_s ? reg_wreq.data : next_second[7:0];
      count_high_second <= wr_hi_s ? reg_wreq.data : next_second[15:8];
    end
  end

  // ************************************************************
  // control and flags; hardware set beats any clear
  // ************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timer_mode_config    <= dtc_pkg::RST_MODE_CONFIG;
      run_bit_first        <= dtc_pkg::RST_CONTROL_FLAGS[dtc_pkg::POS_RUN_FIRST];
      run_bit_second       <= dtc_pkg::RST_CONTROL_FLAGS[dtc_pkg::POS_RUN_SECOND];
      overflow_flag_first  <= dtc_pkg::RST_CONTROL_FLAGS[dtc_pkg::POS_OVF_FIRST];
      overflow_flag_second <= dtc_pkg::RST_CONTROL_FLAGS[dtc_pkg::POS_OVF_SECOND];
    end else begin
      if (wr_mode) begin
        timer_mode_config <= reg_wreq.data;
      end
      if (wr_ctl) begin
        run_bit_first  <= reg_wreq.data[dtc_pkg::POS_RUN_FIRST];
        run_bit_second <= reg_wreq.data[dtc_pkg::POS_RUN_SECOND];
      end
      if (set_ovf_first) begin
        overflow_flag_first <= 1'b1;
      end else if (vector_ack_first) begin
        overflow_flag_first <= 1'b0;
      end else if (wr_ctl) begin
        overflow_flag_first <= reg_wreq.data[dtc_pkg::POS_OVF_FIRST];
      end
      if (set_ovf_second) begin
        overflow_flag_second <= 1'b1;
      end else if (vector_ack_second) begin
        overflow_flag_second <= 1'b0;
      end else if (wr_ctl) begin
        overflow_flag_second <= reg_wreq.data[dtc_pkg::POS_OVF_SECOND];
      end
    end
  end

  // ************************************************************
  // read port; external interrupt bits are not held here
  // ************************************************************
  logic [7:0] next_rdata;
  always_comb begin
    case (reg_raddr)
      dtc_pkg::OFS_CONTROL_FLAGS: next_rdata = {overflow_flag_second, run_bit_second,
                                               overflow_flag_first, run_bit_first, 4'h0};
      dtc_pkg::OFS_MODE_CONFIG:   next_rdata = timer_mode_config;
      dtc_pkg::OFS_LOW_FIRST:     next_rdata = count_low_first;
      dtc_pkg::OFS_HIGH_FIRST:    next_rdata = count_high_first;
      dtc_pkg::OFS_LOW_SECOND:    next_rdata = count_low_second;
      dtc_pkg::OFS_HIGH_SECOND:   next_rdata = count_high_second;
      default:                    next_rdata = 8'h00;
    endcase
  end

  // registered read, one cycle after the address
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  write_wins_a: assert property (@(posedge clock) disable iff (rst)
    wr_lo_f |=> count_low_first == $past(reg_wreq.data)) else $error("low byte write lost");
  timer_mode_tick_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_first.mode == dtc_pkg::DTC_MODE_SIXTEEN && !cfg_first.select && run_bit_first
     && !cfg_first.gate && !wr_lo_f && !wr_hi_f && !wr_mode && !wr_ctl)
    |=> count_low_first == $past(count_low_first) + 8'h01) else $error("timer did not tick");
  gate_hold_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_first.gate && !gate_sb[0] && !split_mode && !wr_lo_f && !wr_hi_f)
    |=> $stable(count_low_first)) else $error("gated timer ran with gate low");
  gate_second_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_second.gate && !gate_sb[1] && !wr_lo_s && !wr_hi_s)
    |=> $stable(count_low_second)) else $error("second gated timer ran");
  stopped_second_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_second.mode == dtc_pkg::DTC_MODE_SPLIT && !wr_lo_s && !wr_hi_s)
    |=> $stable({count_high_second, count_low_second})) else $error("stopped timer moved");
  reload_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_first.mode == dtc_pkg::DTC_MODE_RELOAD && tick_first && count_low_first == 8'hFF
     && !wr_lo_f && !wr_hi_f) |=> count_low_first == $past(count_high_first)
     && overflow_flag_first) else $error("reload missed");
  counter_idle_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_first.select && !fall_first && !split_mode && !wr_lo_f && !wr_hi_f)
    |=> $stable(count_low_first)) else $error("counter moved without edge");
  counter_second_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_second.select && !fall_second && !wr_lo_s && !wr_hi_s)
    |=> $stable(count_low_second)) else $error("second counter moved");
  prescale_a: assert property (@(posedge clock) disable iff (rst)
    (cfg_first.mode == dtc_pkg::DTC_MODE_PRESCALE && !wr_lo_f && !wr_hi_f)
    |=> count_low_first[7:5] == $past(count_low_first[7:5])) else $error("prescaler overran");
  split_high_a: assert property (@(posedge clock) disable iff (rst)
    (split_mode && run_bit_second && !wr_hi_f)
    |=> count_high_first == $past(count_high_first) + 8'h01) else $error("split high idle");
  run_stop_a: assert property (@(posedge clock) disable iff (rst)
    (!run_bit_first && !split_mode && !wr_lo_f && !wr_hi_f)
    |=> $stable({count_high_first, count_low_first})) else $error("stopped timer ran");
  flag_set_a: assert property (@(posedge clock) disable iff (rst)
    set_ovf_second |=> overflow_flag_second) else $error("second flag not set");

endmodule // dtc_timer

// File: tb/dtc_pin_model.sv
// dtc_pin_model: far-side model of the two count pins and the two gating pins
// assumes the bench strobes pulse requests and sets gate levels on the rising clock edge

`timescale 1ns/1ns

module dtc_pin_model #(
  parameter int HOLD = 1  // cycles a count pin stays high per pulse
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // requests from the bench, bit 0 first timer, bit 1 second timer
  input  wire logic [1:0] pulse_req,
  input  wire logic [1:0] gate_lvl,
  // pins seen by the block
  output logic [1:0]      count_pin,
  output logic [1:0]      gate_pin
);
  logic [3:0] hold_a;  // high time left on first count pin
  logic [3:0] hold_b;  // high time left on second count pin

  // ************************************************************
  // pulse shaping
  // ************************************************************
  // each level lasts at least one full machine cycle; HOLD of 1 is the fastest legal rate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_a   <= 4'h0;
      hold_b   <= 4'h0;
      gate_pin <= 2'h0;
    end else begin
      hold_a   <= pulse_req[0] ? 4'(HOLD) : ((hold_a != 4'h0) ? hold_a - 4'h1 : 4'h0);
      hold_b   <= pulse_req[1] ? 4'(HOLD) : ((hold_b != 4'h0) ? hold_b - 4'h1 : 4'h0);
      gate_pin <= gate_lvl;  // gate pins change just after an edge, like a real source
    end
  end

  // pins idle low and rise only while a pulse is being held
  assign count_pin = {hold_b != 4'h0, hold_a != 4'h0};
endmodule  // dtc_pin_model

// File: tb/dtc_timer_tb_top.sv
// dtc_timer_tb_top: self-checking bench for the dual timer/counter block
// assumes dtc_pkg is compiled first and the pin model stands for the external pins

`timescale 1ns/1ns

module dtc_timer_tb_top;
  logic               clock;
  logic               rst;
  dtc_pkg::dtc_wreq_t reg_wreq;     // write request
  logic [7:0]         reg_raddr;    // read address
  logic [7:0]         reg_rdata;    // read data
  logic               vector_ack_first;
  logic               vector_ack_second;
  logic [1:0]         pulse_req;    // pulse strobes to the pin model
  logic [1:0]         gate_lvl;     // gate levels to the pin model
  logic [1:0]         count_pin;
  logic [1:0]         gate_pin;
  logic               ovf_first;
  logic               ovf_second;
  logic [7:0]         rv;           // scratch read value
  int                 error_cnt;
  int                 n_compared;

  // ************************************************************
  // instances
  // ************************************************************
  dtc_timer uut (
    .clock(clock), .rst(rst), .reg_wreq(reg_wreq), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
    .vector_ack_first(vector_ack_first), .vector_ack_second(vector_ack_second),
    .count_pin_first(count_pin[0]), .count_pin_second(count_pin[1]),
    .gate_pin_first(gate_pin[0]), .gate_pin_second(gate_pin[1]),
    .overflow_flag_first(ovf_first), .overflow_flag_second(ovf_second)
  );
  dtc_pin_model #(.HOLD(1)) pins (
    .clock(clock), .rst(rst), .pulse_req(pulse_req), .gate_lvl(gate_lvl),
    .count_pin(count_pin), .gate_pin(gate_pin)
  );

  // 20 MHz core clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ************************************************************
  // bus and compare tasks
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) reg_wreq <= {1'b1, a, d};
    @(posedge clock) reg_wreq.wr <= 1'b0;  // write is taken at this edge
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // registered read: data stands one cycle after the address
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) reg_raddr <= a;
    @(posedge clock) #1 chk8(nm, e, reg_rdata);
  endtask

  // run the timers in mask for exactly n increments, then stop them
  task automatic run_for(input logic [7:0] mask, input int n);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, mask);
    repeat (n - 2) @(posedge clock);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h00);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_values;
    for (int i = 0; i < 6; i++) rdchk("reset value", 8'h88 + 8'(i), 8'h00);
    rdchk("unmapped read", 8'h80, 8'h00);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h0F);  // low nibble is not implemented here
    rdchk("control low nibble", dtc_pkg::OFS_CONTROL_FLAGS, 8'h00);
  endtask

  task automatic t_sixteen_bit;
    wr(dtc_pkg::OFS_MODE_CONFIG, 8'h11);
    wr(dtc_pkg::OFS_LOW_FIRST, 8'hFA);
    wr(dtc_pkg::OFS_HIGH_FIRST, 8'h12);
    run_for(8'h10, 10);
    rdchk("low first", dtc_pkg::OFS_LOW_FIRST, 8'h04);
    rdchk("high first carry", dtc_pkg::OFS_HIGH_FIRST, 8'h13);
    rdchk("second idle", dtc_pkg::OFS_LOW_SECOND, 8'h00);
    // a byte write in mid-run replaces the count, then counting resumes
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h10);
    wr(dtc_pkg::OFS_LOW_FIRST, 8'h50);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h00);
    rdchk("write over count", dtc_pkg::OFS_LOW_FIRST, 8'h52);
  endtask

  // run to an overflow, check the flag, clear it by vector acknowledge, stop
  task automatic ovf_case(input bit sel, input logic [7:0] mask, input logic [7:0] a, input logic [7:0] e);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, mask);
    repeat (4) @(posedge clock);
    #1 chk1("overflow flag set", 1'b1, sel ? ovf_second : ovf_first);
    @(posedge clock) begin
      vector_ack_first  <= ~sel;
      vector_ack_second <= sel;
    end
    @(posedge clock) begin
      vector_ack_first  <= 1'b0;
      vector_ack_second <= 1'b0;
    end
    #1 chk1("overflow flag cleared", 1'b0, sel ? ovf_second : ovf_first);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h00);
    rdchk("count after overflow", a, e);
  endtask

  task automatic t_prescale_and_reload;
    wr(dtc_pkg::OFS_MODE_CONFIG, 8'h20);
    wr(dtc_pkg::OFS_HIGH_FIRST, 8'hFF);
    wr(dtc_pkg::OFS_LOW_FIRST, 8'h1E);
    ovf_case(1'b0, 8'h10, dtc_pkg::OFS_HIGH_FIRST, 8'h00);
    wr(dtc_pkg::OFS_HIGH_SECOND, 8'hF0);
    wr(dtc_pkg::OFS_LOW_SECOND, 8'hFE);
    ovf_case(1'b1, 8'h40, dtc_pkg::OFS_LOW_SECOND, 8'hF6);
    rdchk("reload value kept", dtc_pkg::OFS_HIGH_SECOND, 8'hF0);
  endtask

  task automatic t_split_and_stop;
    wr(dtc_pkg::OFS_MODE_CONFIG, 8'h33);
    wr(dtc_pkg::OFS_LOW_FIRST, 8'h00);
    wr(dtc_pkg::OFS_HIGH_FIRST, 8'h00);
    wr(dtc_pkg::OFS_LOW_SECOND, 8'h00);
    run_for(8'h10, 10);
    rdchk("split low", dtc_pkg::OFS_LOW_FIRST, 8'h0A);
    rdchk("split high idle", dtc_pkg::OFS_HIGH_FIRST, 8'h00);
    run_for(8'h40, 10);
    rdchk("split high", dtc_pkg::OFS_HIGH_FIRST, 8'h0A);
    rdchk("split low idle", dtc_pkg::OFS_LOW_FIRST, 8'h0A);
    rdchk("second stopped", dtc_pkg::OFS_LOW_SECOND, 8'h00);
  endtask

  task automatic t_counter_pins;
    wr(dtc_pkg::OFS_MODE_CONFIG, 8'h55);
    wr(dtc_pkg::OFS_LOW_FIRST, 8'h00);
    wr(dtc_pkg::OFS_HIGH_FIRST, 8'h00);
    wr(dtc_pkg::OFS_LOW_SECOND, 8'h00);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h50);
    // pulses at half the clock rate: one cycle high, one cycle low
    for (int i = 0; i < 5; i++) begin
      @(posedge clock) pulse_req <= {i < 3, 1'b1};
      @(posedge clock) pulse_req <= 2'b00;
    end
    repeat (8) @(posedge clock);
    wr(dtc_pkg::OFS_CONTROL_FLAGS, 8'h00);
    rdchk("pin events first", dtc_pkg::OFS_LOW_FIRST, 8'h05);
    rdchk("pin events second", dtc_pkg::OFS_LOW_SECOND, 8'h03);
    rdchk("no clock counting", dtc_pkg::OFS_HIGH_FIRST, 8'h00);
  endtask

  task automatic t_gating;
    wr(dtc_pkg::OFS_MODE_CONFIG, 8'h99);
    wr(dtc_pkg::OFS_LOW_FIRST, 8'h00);
    wr(dtc_pkg::OFS_LOW_SECOND, 8'h00);
    @(posedge clock) gate_lvl <= 2'b01;
    repeat (6) @(posedge clock);  // let the gate settle through the synchronisers
    run_for(8'h50, 10);
    rdchk("gated first", dtc_pkg::OFS_LOW_FIRST, 8'h0A);
    rdchk("gated second", dtc_pkg::OFS_LOW_SECOND, 8'h00);
    @(posedge clock) gate_lvl <= 2'b10;
    repeat (6) @(posedge clock);
    run_for(8'h50, 10);
    rdchk("gated first held", dtc_pkg::OFS_LOW_FIRST, 8'h0A);
    rdchk("gated second runs", dtc_pkg::OFS_LOW_SECOND, 8'h0A);
  endtask

  // ************************************************************
  // verdict
  // ************************************************************
  task automatic end_of_test;
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    end_of_test();
  end

  // main sequence
  initial begin
    rst               = 1'b1;
    reg_wreq          = '0;
    reg_raddr         = 8'h00;
    vector_ack_first  = 1'b0;
    vector_ack_second = 1'b0;
    pulse_req         = 2'b00;
    gate_lvl          = 2'b00;
    error_cnt         = 0;
    n_compared        = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_reset_values();
    t_sixteen_bit();
    t_prescale_and_reload();
    t_split_and_stop();
    t_counter_pins();
    t_gating();
    end_of_test();
  end
endmodule  // dtc_timer_tb_top
